// ==== design/multimode_io_port_pin.sv ====
// register bus front end and pin array of the multimode io port
// Function
// - quasi mode drives high weakly except just after a latch rise
// - quasi latch one enables very weak pull-up
// - weak pull-up needs latch one, pin high
// - pin dragged low drops weak pull-up
// - latch rise gives two-cycle strong pull-up
// - quasi latch zero drives pin low strongly
// - one pull-down shared by three output modes
// - push-pull holds strong pull-up while one
// - push-pull reads through quasi input path
// - input-only disables all pulls and drives
// - open-drain: no pull-ups, pull-down on zero
// - open-drain needs external pull-up for high
// - port access completes in four clocks
// - after reset every pin but the select pin weakly pulled high
// - select pin reset level follows stored setting
// - two mode registers, one bit per pin
`timescale 1ns/1ps
module multimode_io_port_pin
  import io_port_pkg::*;
#(
  parameter int unsigned WIDTH    = PORT_WIDTH_DEF,
  parameter int unsigned RSEL_PIN = RSEL_PIN_DEF
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire wb_req_t          wb_i,
  output wb_rsp_t               wb_o,
  input  wire logic             reset_level_cfg,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0]      pull_down_en,
  output logic [WIDTH-1:0]      strong_pu_en,
  output logic [WIDTH-1:0]      weak_pu_en,
  output logic [WIDTH-1:0]      very_weak_pu_en,
  output logic [WIDTH-1:0]      pad_o,
  output logic [WIDTH-1:0]      pad_oe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  bus_state_t state_q;
  bus_state_t state_d;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  logic [31:0] rd_q;

  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] latch_d;

  logic [WIDTH-1:0] mode_hi_q;
  logic [WIDTH-1:0] mode_hi_d;

  logic [WIDTH-1:0] mode_lo_q;
  logic [WIDTH-1:0] mode_lo_d;

  logic cfg_s1_q;
  logic cfg_s2_q;

  logic [1:0] init_cnt_q;
  logic       strap_done_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic req_w;
  logic wr_w;
  logic hit_latch_w;
  logic hit_hi_w;
  logic hit_lo_w;
  logic hit_pin_w;
  logic hit_pu_w;
  logic load_rd_w;
  logic load_strap_w;

  logic [WIDTH-1:0] pin_level_w;
  logic [WIDTH-1:0] rd_sel_w;
  logic [31:0]      rd_data_w;
  logic [WIDTH-1:0] wr_data_w;

  assign req_w = wb_i.cyc & wb_i.stb;

  assign wr_w = req_w
              & wb_i.we
              & wb_i.sel[0]
              & (state_q == BUS_ACK);

  assign hit_latch_w = (wb_i.adr == OFS_LATCH);
  assign hit_hi_w    = (wb_i.adr == OFS_MODE_HI);
  assign hit_lo_w    = (wb_i.adr == OFS_MODE_LO);
  assign hit_pin_w   = (wb_i.adr == OFS_PIN);
  assign hit_pu_w    = (wb_i.adr == OFS_PULLUP);

  assign wr_data_w = wb_i.dat[WIDTH-1:0];

  assign rd_sel_w = hit_latch_w ? latch_q
                  : hit_hi_w    ? mode_hi_q
                  : hit_lo_w    ? mode_lo_q
                  : hit_pin_w   ? pin_level_w
                  : hit_pu_w    ? weak_pu_en
                  : '0;

  assign rd_data_w = {{(32 - WIDTH){1'b0}}, rd_sel_w};

  assign load_rd_w = (state_q == BUS_WAIT)
                   & req_w
                   & (cnt_q == ACCESS_LAST);

  assign load_strap_w = !strap_done_q
                      & (init_cnt_q == STRAP_WAIT);

  // ----------------------------------------
  // bus access sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      BUS_IDLE: begin
        if (req_w) begin
          state_d = BUS_WAIT;
          cnt_d   = 3'h1;
        end
      end
      BUS_WAIT: begin
        if (!req_w) begin
          state_d = BUS_IDLE;
        end else if (cnt_q == ACCESS_LAST) begin
          state_d = BUS_ACK;
        end else begin
          cnt_d = 3'(cnt_q + 3'h1);
        end
      end
      BUS_ACK: begin
        state_d = BUS_IDLE;
        cnt_d   = 3'h0;
      end
      default: begin
        state_d = BUS_IDLE;
        cnt_d   = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q <= 32'h0;
    end else if (load_rd_w) begin
      rd_q <= rd_data_w;
    end
  end

  assign wb_o.ack = (state_q == BUS_ACK);
  assign wb_o.dat = rd_q;

  // ----------------------------------------
  // reset level strap
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_s1_q     <= 1'b1;
      cfg_s2_q     <= 1'b1;
      init_cnt_q   <= 2'h0;
      strap_done_q <= 1'b0;
    end else begin
      cfg_s1_q <= reset_level_cfg;
      cfg_s2_q <= cfg_s1_q;
      if (!strap_done_q) begin
        init_cnt_q <= 2'(init_cnt_q + 2'h1);
      end
      if (load_strap_w) begin
        strap_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // port and mode registers
  // ----------------------------------------
  always_comb begin
    latch_d   = latch_q;
    mode_hi_d = mode_hi_q;
    mode_lo_d = mode_lo_q;
    if (wr_w && hit_latch_w) begin
      latch_d = wr_data_w;
    end
    if (wr_w && hit_hi_w) begin
      mode_hi_d = wr_data_w;
    end
    if (wr_w && hit_lo_w) begin
      mode_lo_d = wr_data_w;
    end
    if (load_strap_w) begin
      latch_d[RSEL_PIN] = cfg_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q   <= LATCH_RESET[WIDTH-1:0];
      mode_hi_q <= MODE_RESET[WIDTH-1:0];
      mode_lo_q <= MODE_RESET[WIDTH-1:0];
    end else begin
      latch_q   <= latch_d;
      mode_hi_q <= mode_hi_d;
      mode_lo_q <= mode_lo_d;
    end
  end

  // ----------------------------------------
  // pin array
  // ----------------------------------------
  pin_drive_t drive_w [WIDTH];

  for (genvar gi = 0; gi < WIDTH; gi++) begin : g_pin
    io_mode_t mode_w;
    assign mode_w = io_mode_t'({mode_hi_q[gi], mode_lo_q[gi]});

    io_pin_cell u_cell (
      .clk       (clk),
      .rst_n     (rst_n),
      .mode      (mode_w),
      .latch     (latch_q[gi]),
      .pin_in    (pin_in[gi]),
      .drive     (drive_w[gi]),
      .pin_level (pin_level_w[gi])
    );

    assign pull_down_en[gi]    = drive_w[gi].pd;
    assign strong_pu_en[gi]    = drive_w[gi].pu_strong;
    assign weak_pu_en[gi]      = drive_w[gi].pu_weak;
    assign very_weak_pu_en[gi] = drive_w[gi].pu_vweak;
    assign pad_o[gi]           = drive_w[gi].pu_strong;
    assign pad_oe[gi]          = drive_w[gi].pd | drive_w[gi].pu_strong;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_access_four_clocks: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == BUS_IDLE && req_w) |=> (!wb_o.ack)[*3] ##1 (wb_o.ack || !req_w))
    else $error("port access not answered in four clocks");

  a_ack_single_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    wb_o.ack |=> !wb_o.ack)
    else $error("ack held longer than one cycle");

  a_write_latch_takes: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_w && hit_latch_w && !load_strap_w) |=> latch_q == $past(wr_data_w))
    else $error("latch write not taken at ack");

  a_read_data_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (load_rd_w && hit_latch_w) |=> wb_o.ack && wb_o.dat[WIDTH-1:0] == $past(latch_q))
    else $error("read data not ready with ack");

  a_reset_pins_high: assert property (@(posedge clk)
    !rst_n |=> latch_q == LATCH_RESET[WIDTH-1:0] && mode_hi_q == '0 && mode_lo_q == '0)
    else $error("reset state not quasi and high");

  a_strap_level: assert property (@(posedge clk) disable iff (!rst_n)
    load_strap_w |=> latch_q[RSEL_PIN] == $past(cfg_s2_q) && strap_done_q)
    else $error("reset level select not applied");

  a_strap_once: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> ##2 load_strap_w)
    else $error("reset level select not loaded two cycles after release");

  a_quasi_low_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (!mode_hi_q[0] && !mode_lo_q[0] && !latch_q[0]) |-> pull_down_en[0] && pad_oe[0]
      && !pad_o[0] && !very_weak_pu_en[0])
    else $error("quasi pin zero not driven low");

  a_push_pull_high: assert property (@(posedge clk) disable iff (!rst_n)
    (!mode_hi_q[0] && mode_lo_q[0] && latch_q[0]) |-> strong_pu_en[0] && !pull_down_en[0])
    else $error("push-pull one lacks strong pull-up");

  c_write_latch: cover property (@(posedge clk) disable iff (!rst_n)
    wr_w && hit_latch_w);

  c_read_pins: cover property (@(posedge clk) disable iff (!rst_n)
    load_rd_w && hit_pin_w ##1 wb_o.ack);

  c_mode_change: cover property (@(posedge clk) disable iff (!rst_n)
    wr_w && hit_hi_w ##6 wr_w && hit_lo_w);

  c_strap_low: cover property (@(posedge clk) disable iff (!rst_n)
    load_strap_w && !cfg_s2_q);

endmodule

// ==== include/io_port_pkg.sv ====
// shared constants and types of the multimode io port
package io_port_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int unsigned PORT_WIDTH_DEF = 8;
  localparam int unsigned ADR_WIDTH      = 8;
  localparam int unsigned ACCESS_CYCLES  = 4;
  localparam logic [2:0]  ACCESS_LAST    = 3'(ACCESS_CYCLES - 1);
  localparam int unsigned STRONG_CYCLES  = 2;
  localparam logic [1:0]  STRONG_HOLD    = 2'(STRONG_CYCLES - 1);
  localparam logic [1:0]  STRAP_WAIT     = 2'h2;
  localparam int unsigned RSEL_PIN_DEF   = 0;

  // ----------------------------------------
  // register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] OFS_LATCH   = 8'h00;
  localparam logic [7:0] OFS_MODE_HI = 8'h04;
  localparam logic [7:0] OFS_MODE_LO = 8'h08;
  localparam logic [7:0] OFS_PIN     = 8'h0c;
  localparam logic [7:0] OFS_PULLUP  = 8'h10;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET  = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_QUASI      = 2'b00,
    MODE_PUSH_PULL  = 2'b01,
    MODE_INPUT_ONLY = 2'b10,
    MODE_OPEN_DRAIN = 2'b11
  } io_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [ADR_WIDTH-1:0] adr;
    logic [3:0]           sel;
    logic [31:0]          dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic pd;
    logic pu_strong;
    logic pu_weak;
    logic pu_vweak;
  } pin_drive_t;

endpackage

// ==== design/io_pin_cell.sv ====
// per-pin drive and input logic of the io port
`timescale 1ns/1ps
module io_pin_cell
  import io_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire io_mode_t   mode,
  input  wire logic       latch,
  input  wire logic       pin_in,
  output pin_drive_t      drive,
  output logic            pin_level
);

  // ----------------------------------------
  // input path
  // ----------------------------------------
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       prev_q;
  logic [1:0] hold_q;
  logic [1:0] hold_d;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      prev_q   <= 1'b1;
      hold_q   <= 2'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      prev_q   <= latch;
      hold_q   <= hold_d;
    end
  end

  assign pin_level = pin_s2_q;

  // ----------------------------------------
  // drive decode
  // ----------------------------------------
  logic quasi_w;
  logic pp_w;
  logic rise_w;
  assign quasi_w = (mode == MODE_QUASI);
  assign pp_w    = (mode == MODE_PUSH_PULL);
  assign rise_w  = quasi_w & latch & ~prev_q;
  assign hold_d  = rise_w ? STRONG_HOLD : (hold_q != 2'h0 && latch) ? 2'(hold_q - 2'h1) : 2'h0;

  assign drive.pd        = ~latch & (mode != MODE_INPUT_ONLY);
  assign drive.pu_strong = latch & (pp_w | (quasi_w & (rise_w | hold_q != 2'h0)));
  assign drive.pu_vweak  = quasi_w & latch;
  assign drive.pu_weak   = quasi_w & latch & pin_s2_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_strong_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
    rise_w |-> drive.pu_strong ##1 (drive.pu_strong || !latch || !quasi_w)
      ##1 (!drive.pu_strong || !quasi_w || !$stable(latch)))
    else $error("strong pull-up not held for two cycles");
  a_weak_drop_low: assert property (@(posedge clk) disable iff (!rst_n)
    (quasi_w && latch && $fell(pin_s2_q)) |-> !drive.pu_weak && drive.pu_vweak)
    else $error("weak pull-up kept while pin pulled low");
  a_input_only_off: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == MODE_INPUT_ONLY) |-> drive == '0)
    else $error("drive active in input-only mode");
  a_open_drain_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == MODE_OPEN_DRAIN) |-> !drive.pu_strong && !drive.pu_weak && !drive.pu_vweak
      && drive.pd == !latch)
    else $error("open-drain drive wrong");
  a_input_sync_two: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> pin_level == $past(pin_in, 2))
    else $error("pin level not two-flop delayed");
  c_strong_pulse: cover property (@(posedge clk) disable iff (!rst_n)
    rise_w ##1 drive.pu_strong ##1 !drive.pu_strong);

endmodule

// ==== tb/pin_load_model.sv ====
// outside load model: strong pad drivers, outside sinks and board pull-up
`timescale 1ns/1ps
module pin_load_model
  import io_port_pkg::*;
#(
  parameter int unsigned WIDTH = PORT_WIDTH_DEF
)(
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] pad_o,
  input  wire logic [WIDTH-1:0] pad_oe,
  input  wire logic [WIDTH-1:0] weak_pu_en,
  input  wire logic [WIDTH-1:0] very_weak_pu_en,
  input  wire logic [WIDTH-1:0] ext_low,
  input  wire logic             ext_pullup,
  output logic [WIDTH-1:0]      pin_in
);
  // ----------------------------------------
  // pad level
  // ----------------------------------------
  logic [WIDTH-1:0] pulled;
  logic [WIDTH-1:0] float_q = '0;

  // outside sink beats any weak pull-up, loses to a strong driver
  assign pulled = weak_pu_en | very_weak_pu_en | {WIDTH{ext_pullup}};
  assign pin_in = (pad_oe & pad_o) | (~pad_oe & ~ext_low & (pulled | float_q));

  // an undriven pad wanders every cycle
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
endmodule

// ==== tb/multimode_io_port_pin_test.sv ====
// self-checking bench of the multimode io port
`timescale 1ns/1ps
module multimode_io_port_pin_test
  import io_port_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clk;
  logic       rst_n;
  wb_req_t    wb_i;
  wb_rsp_t    wb_o;
  logic       reset_level_cfg;
  logic [7:0] pin_in;
  logic [7:0] pull_down_en;
  logic [7:0] strong_pu_en;
  logic [7:0] weak_pu_en;
  logic [7:0] very_weak_pu_en;
  logic [7:0] pad_o;
  logic [7:0] pad_oe;
  logic [7:0] ext_low;
  logic       ext_pullup;
  logic [7:0] mh, ml, lt, xl;
  logic [4:0] e;
  logic [7:0] ex [5];
  logic [31:0] rd;
  int         num_errors, total_checks, seed, lat;

  multimode_io_port_pin #(.WIDTH(8), .RSEL_PIN(0)) multimode_io_port_pin_i (
    .clk(clk), .rst_n(rst_n), .wb_i(wb_i), .wb_o(wb_o),
    .reset_level_cfg(reset_level_cfg), .pin_in(pin_in),
    .pull_down_en(pull_down_en), .strong_pu_en(strong_pu_en),
    .weak_pu_en(weak_pu_en), .very_weak_pu_en(very_weak_pu_en),
    .pad_o(pad_o), .pad_oe(pad_oe));

  pin_load_model #(.WIDTH(8)) pin_load_model_i (
    .clk(clk), .pad_o(pad_o), .pad_oe(pad_oe), .weak_pu_en(weak_pu_en),
    .very_weak_pu_en(very_weak_pu_en), .ext_low(ext_low),
    .ext_pullup(ext_pullup), .pin_in(pin_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_lat(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %0t latency %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                     input logic [3:0] sel = 4'hf);
    int n;
    @(posedge clk);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: {24'h0, dat}};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_o.ack !== 1'b1);
    lat = n;
    rd = wb_o.dat;
    wb_i <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    chk_val(rd[7:0], exp);
    chk_lat(lat, int'(ACCESS_CYCLES) + 1);
  endtask

  function automatic logic [4:0] exp_pin(input logic [1:0] m, input logic l, input logic x);
    logic pd, st, pin;
    pd = !l && m != MODE_INPUT_ONLY;
    st = l && m == MODE_PUSH_PULL;
    pin = pd ? 1'b0 : (st ? 1'b1 : !x);
    return {pin, pd, st, m == MODE_QUASI && l && pin, m == MODE_QUASI && l};
  endfunction

  task automatic do_reset(input logic cfg);
    @(posedge clk);
    rst_n <= 1'b0;
    reset_level_cfg <= cfg;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk_val(very_weak_pu_en, {7'h7f, cfg});
    chk_val(weak_pu_en, {7'h7f, cfg});
    chk_val(pull_down_en, {7'h00, ~cfg});
    rd_chk(OFS_LATCH, {7'h7f, cfg});
    rd_chk(OFS_MODE_HI, 8'h00);
    rd_chk(OFS_MODE_LO, 8'h00);
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'ha851ecf4;
    num_errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    wb_i = '0;
    reset_level_cfg = 1'b0;
    ext_low = 8'h00;
    ext_pullup = 1'b1;
    do_reset(1'b0);
    rd_chk(8'h14, 8'h00);
    bus(1'b1, OFS_LATCH, 8'h00);
    bus(1'b1, OFS_LATCH, 8'hff);
    #1 chk_val(strong_pu_en & pad_oe & pad_o, 8'hff);
    @(posedge clk);
    #1 chk_val(strong_pu_en, 8'hff);
    @(posedge clk);
    #1 chk_val(strong_pu_en, 8'h00);
    bus(1'b1, OFS_LATCH, 8'h5a, 4'he);
    rd_chk(OFS_LATCH, 8'hff);
    for (int i = 0; i < 10; i++) begin
      mh = (i == 0) ? 8'hcc : 8'($random(seed));
      ml = (i == 0) ? 8'haa : 8'($random(seed));
      lt = 8'($random(seed));
      xl = 8'($random(seed));
      bus(1'b1, OFS_MODE_HI, mh);
      bus(1'b1, OFS_MODE_LO, ml);
      bus(1'b1, OFS_LATCH, lt);
      ext_low <= xl;
      repeat (6) @(posedge clk);
      for (int b = 0; b < 8; b++) begin
        e = exp_pin({mh[b], ml[b]}, lt[b], xl[b]);
        for (int k = 0; k < 5; k++) ex[k][b] = e[k];
      end
      #1;
      chk_val(pull_down_en, ex[3]);
      chk_val(strong_pu_en, ex[2]);
      chk_val(weak_pu_en, ex[1]);
      chk_val(very_weak_pu_en, ex[0]);
      chk_val(pad_oe, ex[3] | ex[2]);
      chk_val(pad_o, ex[2]);
      rd_chk(OFS_PIN, ex[4]);
      rd_chk(OFS_PULLUP, ex[1]);
      rd_chk(OFS_MODE_HI, mh);
      rd_chk(OFS_MODE_LO, ml);
      rd_chk(OFS_LATCH, lt);
    end
    ext_low <= 8'h00;
    do_reset(1'b1);
    end_of_test();
  end
endmodule
